//--- verilog/ebwsg_consts.vh
// Constants for the external bus wait-state generator.
`ifndef EBWSG_CONSTS_VH
`define EBWSG_CONSTS_VH
`define EBWSG_CTRL_IO_ADDR 16'hFFFF
`define EBWSG_PS_LSB 0
`define EBWSG_PS_MSB 2
`define EBWSG_DS_LSB 3
`define EBWSG_DS_MSB 5
`define EBWSG_IS_LSB 6
`define EBWSG_IS_MSB 8
`define EBWSG_VIS_LSB 9
`define EBWSG_VIS_MSB 10
`define EBWSG_WAIT_RESET 3'h7
`define EBWSG_VIS_RESET 2'h3
`define EBWSG_VIS_DATA 2'h2
`define EBWSG_VIS_PROG 2'h3
`define EBWSG_SPACE_PROG 2'h0
`define EBWSG_SPACE_DATA 2'h1
`define EBWSG_SPACE_IO 2'h2
`endif

//--- verilog/ebwsg_wait_counter.v
// Down counter that holds an external access for its programmed wait count.
`timescale 1ns/1ps
module ebwsg_wait_counter
(
    // Clock and reset.
    input wire clk_i,
    input wire resetn_i,
    // Control.
    input wire load_i,
    input wire [2:0] count_i,
    // Status.
    output wire zero_o
);
    // Remaining programmed wait cycles.
    reg [2:0] remain;

    // Load during the base cycle of an access, then count down to zero.
    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            remain <= 3'h0;
        end
        else if (load_i)
        begin
            remain <= count_i;
        end
        else if (remain != 3'h0)
        begin
            remain <= remain - 3'h1;
        end
    end

    // High once the programmed count has run out.
    assign zero_o = (remain == 3'h0);
endmodule

//--- verilog/ebwsg_top.v
// Wait-state generator and bus-visibility control for the external memory interface.
// What this block does
// - Three-bit field gives zero to seven waits.
// - Bits 2-0 set program space waits.
// - Bits 5-3 set data space waits.
// - Bits 8-6 set I/O space waits.
// - Ready stretches access, never shortens count.
// - Reset sets all wait fields to seven.
// - Bits 10-9 select trace; reset gives 11.
// - Bit ten low disables bus trace output.
// - Mode 10 traces data address and data.
// - Mode 11 traces program address and data.
// - Bits 15-11 always read as zero.
// - Register sits at top I/O address.
`timescale 1ns/1ps
`include "ebwsg_consts.vh"
module ebwsg_top
(
    // Clock and reset.
    input wire clk_i,
    input wire resetn_i,
    // CPU I/O space register port.
    input wire io_wr_i,
    input wire io_rd_i,
    input wire [15:0] io_addr_i,
    input wire [15:0] io_wdata_i,
    output reg [15:0] io_rdata_o,
    // External access request from the core.
    input wire acc_start_i,
    input wire [1:0] acc_space_i,
    input wire [15:0] acc_addr_i,
    // External ready pin.
    input wire ready_i,
    // Access status back to the core.
    output reg acc_busy_o,
    output reg acc_done_o,
    // External strobe and address.
    output reg ext_strobe_o,
    output reg [15:0] ext_addr_o,
    // Internal buses for visibility tracing.
    input wire internal_run_i,
    input wire [15:0] prog_addr_i,
    input wire [15:0] prog_data_i,
    input wire [15:0] data_addr_i,
    input wire [15:0] data_data_i,
    // Trace outputs onto the external pins.
    output reg trace_oe_o,
    output reg [15:0] trace_addr_o,
    output reg [15:0] trace_data_o
);
    // Control register fields.
    reg [2:0] program_space_wait_count;
    reg [2:0] data_space_wait_count;
    reg [2:0] io_space_wait_count;
    reg [1:0] bus_trace_select;
    // Ready pin synchroniser stages.
    reg ready_meta;
    reg ready_sync;
    // Access state.
    reg in_access;
    reg base_done;
    // Wait count latched when the access is taken, so a later write cannot change it.
    reg [2:0] acc_wait;
    // Wait count chosen for the starting access.
    reg [2:0] next_wait;
    // Counter status.
    wire wait_zero;
    // Register hit decode.
    wire reg_hit;

    // The control register answers only at the topmost I/O address.
    assign reg_hit = (io_addr_i == `EBWSG_CTRL_IO_ADDR);

    // Register write and reset values.
    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            program_space_wait_count <= `EBWSG_WAIT_RESET;
            data_space_wait_count <= `EBWSG_WAIT_RESET;
            io_space_wait_count <= `EBWSG_WAIT_RESET;
            bus_trace_select <= `EBWSG_VIS_RESET;
        end
        else if (io_wr_i && reg_hit)
        begin
            program_space_wait_count <= io_wdata_i[`EBWSG_PS_MSB:`EBWSG_PS_LSB];
            data_space_wait_count <= io_wdata_i[`EBWSG_DS_MSB:`EBWSG_DS_LSB];
            io_space_wait_count <= io_wdata_i[`EBWSG_IS_MSB:`EBWSG_IS_LSB];
            bus_trace_select <= io_wdata_i[`EBWSG_VIS_MSB:`EBWSG_VIS_LSB];
        end
    end

    // Registered read data; unmapped addresses and reserved bits read zero.
    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            io_rdata_o <= 16'h0000;
        end
        else if (io_rd_i && reg_hit)
        begin
            io_rdata_o <= {5'h00, bus_trace_select, io_space_wait_count,
                           data_space_wait_count, program_space_wait_count};
        end
        else
        begin
            io_rdata_o <= 16'h0000;
        end
    end

    // Ready comes from a pin, so it passes two flip-flops first.
    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            ready_meta <= 1'b1;
            ready_sync <= 1'b1;
        end
        else
        begin
            ready_meta <= ready_i;
            ready_sync <= ready_meta;
        end
    end

    // Select the wait field for the space of the starting access.
    always @*
    begin
        case (acc_space_i)
            `EBWSG_SPACE_PROG: next_wait = program_space_wait_count;
            `EBWSG_SPACE_DATA: next_wait = data_space_wait_count;
            `EBWSG_SPACE_IO: next_wait = io_space_wait_count;
            default: next_wait = program_space_wait_count;
        endcase
    end

    // Counter loads the latched count during the base cycle, so the base cycle never eats a wait.
    // Loading it at the start edge instead made one wait state look the same as none.
    ebwsg_wait_counter u_wait
    (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .load_i(in_access && !base_done),
        .count_i(acc_wait),
        .zero_o(wait_zero)
    );

    // Access sequencer: one base cycle, the programmed waits, then ready.
    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            in_access <= 1'b0;
            base_done <= 1'b0;
            acc_wait <= 3'h0;
            acc_busy_o <= 1'b0;
            acc_done_o <= 1'b0;
            ext_strobe_o <= 1'b0;
            ext_addr_o <= 16'h0000;
        end
        else if (!in_access)
        begin
            acc_done_o <= 1'b0;
            base_done <= 1'b0;
            if (acc_start_i)
            begin
                // Start: strobe and address held stable until the end.
                in_access <= 1'b1;
                acc_busy_o <= 1'b1;
                ext_strobe_o <= 1'b1;
                ext_addr_o <= acc_addr_i;
                // The field of this space is frozen here for the whole access.
                acc_wait <= next_wait;
            end
        end
        else if (!base_done)
        begin
            // The base cycle has now elapsed.
            base_done <= 1'b1;
        end
        else if (wait_zero && ready_sync)
        begin
            // Waits spent and ready seen: finish, early ready ignored before.
            in_access <= 1'b0;
            acc_busy_o <= 1'b0;
            acc_done_o <= 1'b1;
            ext_strobe_o <= 1'b0;
        end
    end

    // Bus visibility: mirror the selected internal bus while running internally and no external access is in progress.
    always @(posedge clk_i)
    begin
        if (!resetn_i)
        begin
            trace_oe_o <= 1'b0;
            trace_addr_o <= 16'h0000;
            trace_data_o <= 16'h0000;
        end
        else if (bus_trace_select[1] && internal_run_i && !in_access)
        begin
            trace_oe_o <= 1'b1;
            if (bus_trace_select == `EBWSG_VIS_PROG)
            begin
                trace_addr_o <= prog_addr_i;
                trace_data_o <= prog_data_i;
            end
            else
            begin
                trace_addr_o <= data_addr_i;
                trace_data_o <= data_data_i;
            end
        end
        else
        begin
            // Bit ten low, not running internally, or an external access in progress: nothing driven onto the pins.
            trace_oe_o <= 1'b0;
            trace_addr_o <= 16'h0000;
            trace_data_o <= 16'h0000;
        end
    end
endmodule

//--- dv/ebwsg_chk.sv
// Port assertions for the wait-state generator.
`timescale 1ns/1ps
module ebwsg_chk
(
    input wire clk_i, resetn_i, io_rd_i, acc_start_i,
    input wire acc_busy_o, acc_done_o, ext_strobe_o, trace_oe_o,
    input wire [15:0] io_addr_i, io_rdata_o, acc_addr_i,
    input wire [15:0] ext_addr_o, trace_addr_o, trace_data_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_rsv; io_rdata_o[15:11] == 5'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_bad; io_rd_i && io_addr_i != 16'hFFFF |=> io_rdata_o == 16'h0; endproperty
    a_bad: assert property (p_bad) else $error("stray read data");
    property p_off; !trace_oe_o |-> trace_addr_o == 16'h0 && trace_data_o == 16'h0; endproperty
    a_off: assert property (p_off) else $error("trace driven while off");
    property p_same; acc_busy_o == ext_strobe_o; endproperty
    a_same: assert property (p_same) else $error("strobe and busy differ");
    property p_go; acc_start_i && !acc_busy_o |=> ext_strobe_o && ext_addr_o == $past(acc_addr_i); endproperty
    a_go: assert property (p_go) else $error("access not started");
    property p_min; $rose(ext_strobe_o) |-> ext_strobe_o[*2]; endproperty
    a_min: assert property (p_min) else $error("strobe too short");
    property p_end; $rose(acc_busy_o) |-> ##[2:60] acc_done_o; endproperty
    a_end: assert property (p_end) else $error("access never ends");
    property p_done; acc_done_o |-> $past(acc_busy_o) && !ext_strobe_o; endproperty
    a_done: assert property (p_done) else $error("done without access");
    property p_hold; acc_busy_o && $past(acc_busy_o) |-> $stable(ext_addr_o); endproperty
    a_hold: assert property (p_hold) else $error("address moved");
endmodule
bind ebwsg_top ebwsg_chk u_chk(.*);

//--- dv/ebwsg_mem_model.sv
// Slow external memory that stretches accesses through its ready line.
`timescale 1ns/1ps
module ebwsg_mem_model
(
    input wire clk_i,
    input wire strobe_i,
    input wire [3:0] stall_i,
    output reg ready_o
);
    reg [3:0] cnt = 4'h0;
    initial ready_o = 1'b1;
    // Ready is low for the first stall_i cycles of each access, high when idle.
    always @(posedge clk_i)
    begin
        cnt <= strobe_i ? cnt + 4'h1 : 4'h0;
        ready_o <= !(strobe_i && cnt < stall_i);
    end
endmodule

//--- dv/tb.sv
// Self-checking bench for the wait-state generator.
`timescale 1ns/1ps
module tb;
    reg clk_i = 1'b0, resetn_i = 1'b0, io_wr_i = 1'b0, io_rd_i = 1'b0;
    reg acc_start_i = 1'b0, internal_run_i = 1'b0;
    reg [15:0] io_addr_i = 16'h0, io_wdata_i = 16'h0, acc_addr_i = 16'h0;
    reg [1:0] acc_space_i = 2'h0;
    reg [3:0] stall = 4'h0;
    reg [2:0] k;
    wire ready_i, acc_busy_o, acc_done_o, ext_strobe_o, trace_oe_o;
    wire [15:0] io_rdata_o, ext_addr_o, trace_addr_o, trace_data_o;
    integer mismatches = 0, samples_checked = 0, i, len;
    always #20 clk_i = ~clk_i;
    ebwsg_top uut(.clk_i(clk_i), .resetn_i(resetn_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
        .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
        .acc_start_i(acc_start_i), .acc_space_i(acc_space_i), .acc_addr_i(acc_addr_i),
        .ready_i(ready_i), .acc_busy_o(acc_busy_o), .acc_done_o(acc_done_o),
        .ext_strobe_o(ext_strobe_o), .ext_addr_o(ext_addr_o), .internal_run_i(internal_run_i),
        .prog_addr_i(16'hA1A1), .prog_data_i(16'hA2A2), .data_addr_i(16'hD1D1),
        .data_data_i(16'hD2D2), .trace_oe_o(trace_oe_o), .trace_addr_o(trace_addr_o),
        .trace_data_o(trace_data_o));
    ebwsg_mem_model mem(.clk_i(clk_i), .strobe_i(ext_strobe_o), .stall_i(stall), .ready_o(ready_i));
    task chk(input [15:0] got, input [15:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task close_out;
    begin
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    // Register access on the I/O port; read data is compared in the cycle it stands.
    task wr(input [15:0] a, input [15:0] d);
    begin
        @(posedge clk_i);
        io_wr_i <= 1'b1;
        io_addr_i <= a;
        io_wdata_i <= d;
        @(posedge clk_i);
        io_wr_i <= 1'b0;
    end
    endtask
    task rd(input [15:0] a, input [15:0] exp);
    begin
        @(posedge clk_i);
        io_rd_i <= 1'b1;
        io_addr_i <= a;
        @(posedge clk_i);
        io_rd_i <= 1'b0;
        #1 chk(io_rdata_o, exp);
    end
    endtask
    // One external access; len gets cycles from the taking edge to done.
    task acc(input [1:0] s);
    begin
        len = 0;
        @(posedge clk_i);
        acc_start_i <= 1'b1;
        acc_space_i <= s;
        acc_addr_i <= 16'hC000 + s;
        @(posedge clk_i);
        acc_start_i <= 1'b0;
        #1;
        while (acc_done_o !== 1'b1 && len < 100)
        begin
            @(posedge clk_i);
            #1 len = len + 1;
        end
        if (len == 100)
        begin
            mismatches = mismatches + 1;
            close_out;
        end
        chk(ext_addr_o, 16'hC000 + s);
    end
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(16'hFFFF, 16'h07FF);
        wr(16'hFFFF, 16'hFFFF);
        wr(16'hFFFE, 16'h0000);
        rd(16'hFFFF, 16'h07FF);
        rd(16'hFFFE, 16'h0000);
        $display("Register test done");
        for (i = 0; i < 8; i = i + 1)
        begin
            k = i;
            wr(16'hFFFF, {7'h0, k + 3'h2, k + 3'h1, k});
            rd(16'hFFFF, {7'h0, k + 3'h2, k + 3'h1, k});
            acc(2'h0);
            chk(len[15:0], {13'h0, k} + 16'h2);
            acc(2'h1);
            chk(len[15:0], {13'h0, k + 3'h1} + 16'h2);
            acc(2'h2);
            chk(len[15:0], {13'h0, k + 3'h2} + 16'h2);
        end
        acc(2'h3);
        chk(len[15:0], 16'h9);
        wr(16'hFFFF, 16'h0005);
        fork
            acc(2'h0);
            begin
                repeat (4) @(posedge clk_i);
                wr(16'hFFFF, 16'h0000);
            end
        join
        chk(len[15:0], 16'h7);
        acc(2'h0);
        chk(len[15:0], 16'h2);
        $display("Wait count test done");
        wr(16'hFFFF, 16'h0007);
        stall = 4'h3;
        acc(2'h0);
        chk(len[15:0], 16'h9);
        wr(16'hFFFF, 16'h0002);
        stall = 4'h8;
        acc(2'h0);
        chk(len[15:0], 16'hC);
        stall = 4'h0;
        $display("Ready test done");
        internal_run_i <= 1'b1;
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(16'hFFFF, {5'h0, i[1:0], 9'h0});
            repeat (2) @(posedge clk_i);
            #1 chk({15'h0, trace_oe_o}, {15'h0, i[1]});
            chk(trace_addr_o, i == 3 ? 16'hA1A1 : i == 2 ? 16'hD1D1 : 16'h0);
            chk(trace_data_o, i == 3 ? 16'hA2A2 : i == 2 ? 16'hD2D2 : 16'h0);
        end
        $display("Trace test done");
        close_out;
    end
endmodule
